/* File: rtl/psc_pkg.sv */
// Constants and types shared by the program sequencer core
// ==========================================================
// Function
// - Each system clock cycle is one phase; four phases make one instruction cycle.
// - Phase one advances the counter and fetches; later phases decode and execute.
// - The next fetch overlaps the current execute: one instruction per cycle.
// - Any counter-changing instruction costs two instruction cycles.
// - The counter steps by one unless the instruction branches away.
// - Jump, call, interrupt entry and reset load the target address.
// - A taken skip discards the fetched word and runs a dummy cycle.
// - The counter is 10 bits; software reaches only the low byte.
// - Writing the low byte jumps inside the current page with one dummy cycle.
// - Two-level return stack, hidden from software and memory spaces.
// - Call and interrupt entry push the counter; returns pop it back.
// - Reset points the stack pointer at the top of the stack.
// - Interrupt with full stack stays pending until a return frees a level.
// - A call on a full stack still runs and drops the oldest entry.
// - The ALU writes its result to the chosen place and updates status flags.
// - Add, subtract, carry forms, decimal adjust, logic, rotates, increment, decrement.
// - Program memory holds 1K words of 14 bits, addressed by the counter.
// - After reset execution starts at address zero.
// - Table read stores the low byte to data memory, the high part to the latch.
// - Latch bits above the 14-bit word read as zero.
// - A table read takes two instruction cycles.
// - The table-high latch is read-only and changes only on table reads.
package psc_pkg;

  // ==========================================================
  // Core geometry
  localparam int unsigned PC_W      = 10;
  localparam int unsigned IW        = 14;
  localparam int unsigned PM_DEPTH  = 1024;
  localparam int unsigned TABLE_HIGH_LATCH_W    = IW - 8;
  localparam int unsigned STK_DEPTH = 2;
  localparam int unsigned AXI_AW    = 8;
  localparam logic [1:0]  SP_FULL   = 2'h2;
  localparam logic [9:0]  RESET_VEC = 10'h000;
  localparam logic [9:0]  IRQ_VEC   = 10'h004;

  // ==========================================================
  // Special data memory locations
  localparam logic [5:0] DA_PCL    = 6'h02;
  localparam logic [5:0] DA_TBLP   = 6'h07;
  localparam logic [5:0] DA_TBHP   = 6'h08;
  localparam logic [5:0] DA_TABLE_HIGH_LATCH   = 6'h09;
  localparam logic [5:0] DA_STATUS = 6'h0A;

  // ==========================================================
  // Instruction classes and ALU operations
  localparam logic [2:0] CLS_ALU  = 3'h0;
  localparam logic [2:0] CLS_JMP  = 3'h1;
  localparam logic [2:0] CLS_CALL = 3'h2;
  localparam logic [2:0] CLS_RET  = 3'h3;
  localparam logic [2:0] CLS_SZ   = 3'h4;
  localparam logic [2:0] CLS_TAB  = 3'h5;
  localparam logic [2:0] CLS_MOV  = 3'h6;
  localparam logic [2:0] CLS_LIT  = 3'h7;
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_ADC = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_SBC = 4'h3;
  localparam logic [3:0] OP_DAA = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_OR  = 4'h6;
  localparam logic [3:0] OP_XOR = 4'h7;
  localparam logic [3:0] OP_CPL = 4'h8;
  localparam logic [3:0] OP_RR  = 4'h9;
  localparam logic [3:0] OP_RRC = 4'hA;
  localparam logic [3:0] OP_RL  = 4'hB;
  localparam logic [3:0] OP_RLC = 4'hC;
  localparam logic [3:0] OP_INC = 4'hD;
  localparam logic [3:0] OP_DEC = 4'hE;

  // ==========================================================
  // Register map and bus answers
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_PADDR = 8'h08;
  localparam logic [7:0] REG_PDATA = 8'h0C;
  localparam logic [7:0] REG_CORE  = 8'h10;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_IRQ = 1;
  localparam int unsigned CTRL_EMI = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} psc_phase_t;

  typedef struct packed {
    logic [2:0] cls;
    logic [3:0] op;
    logic       dst_m;
    logic [5:0] addr;
  } psc_instr_t;

  typedef struct packed {
    logic ac;
    logic c;
    logic z;
  } psc_flags_t;

endpackage

/* File: rtl/psc_core.sv */
// Program sequencer core: phases, pipeline, counter, stack, ALU, table read
`timescale 1ns/1ps
`default_nettype none
module psc_core #(
  parameter int unsigned DM_DEPTH = 64
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic [psc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [psc_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [3:0]                     instruction_phase_clocks
);
  import psc_pkg::*;

  // ==========================================================
  // State
  psc_phase_t      ph_reg;
  psc_phase_t      ph_next;
  logic [3:0]      phclk_reg;
  logic [3:0]      ph_oh;
  logic            run_reg;
  logic            emi_reg;
  logic            pend_reg;
  logic [PC_W-1:0] pc_reg;
  psc_instr_t      fetch_reg;
  psc_instr_t      exec_reg;
  logic            fetch_vld_reg;
  logic            exec_vld_reg;
  logic [PC_W-1:0] stk_reg [STK_DEPTH];
  logic [1:0]      sp_reg;
  logic [7:0]      acc_reg;
  psc_flags_t      flg_reg;
  logic [TABLE_HIGH_LATCH_W-1:0] table_high_latch_reg;
  logic [IW-1:0]   pmem [PM_DEPTH];
  logic [7:0]      dmem [DM_DEPTH];
  logic [PC_W-1:0] paddr_reg;

  // ==========================================================
  // Phase generator: one system clock per phase
  always_comb begin
    case (ph_reg)
      PH_T1:   ph_next = PH_T2;
      PH_T2:   ph_next = PH_T3;
      PH_T3:   ph_next = PH_T4;
      PH_T4:   ph_next = PH_T1;
      default: ph_next = PH_T1;
    endcase
    ph_oh = 4'h1 << ph_next;
  end

  // Phases freeze while stopped so a restart resumes mid-cycle cleanly
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ph_reg    <= PH_T1;
      phclk_reg <= 4'h0;
    end else if (run_reg) begin
      ph_reg    <= ph_next;
      phclk_reg <= ph_oh;
    end
  end
  assign instruction_phase_clocks = phclk_reg;

  // ==========================================================
  // Decode of the executing word
  logic t1_go;
  logic exec_go;
  logic is_alu;
  logic is_jmp;
  logic is_call;
  logic is_ret;
  logic is_sz;
  logic is_tab;
  logic is_mov;
  logic is_lit;
  logic [5:0] da;
  logic [7:0] lit;
  logic [PC_W-1:0] jt;
  assign t1_go   = run_reg && (ph_reg == PH_T1);
  assign exec_go = run_reg && (ph_reg == PH_T4) && exec_vld_reg;
  assign is_alu  = exec_reg.cls == CLS_ALU;
  assign is_jmp  = exec_reg.cls == CLS_JMP;
  assign is_call = exec_reg.cls == CLS_CALL;
  assign is_ret  = exec_reg.cls == CLS_RET;
  assign is_sz   = exec_reg.cls == CLS_SZ;
  assign is_tab  = exec_reg.cls == CLS_TAB;
  assign is_mov  = exec_reg.cls == CLS_MOV;
  assign is_lit  = exec_reg.cls == CLS_LIT;
  assign da      = exec_reg.addr;
  assign lit     = {exec_reg.op[0], exec_reg.dst_m, exec_reg.addr};
  assign jt      = {exec_reg.op[2:0], exec_reg.dst_m, exec_reg.addr};

  // Operand read; counter low byte and latch are mapped into data space
  logic [7:0] mem_rd;
  assign mem_rd = (da == DA_PCL)    ? pc_reg[7:0] :
                  (da == DA_TABLE_HIGH_LATCH)   ? {2'h0, table_high_latch_reg} :
                  (da == DA_STATUS) ? {5'h00, flg_reg} :
                  dmem[da];

  // Table word; the dst_m bit selects the last-page form
  logic [PC_W-1:0] tab_addr;
  logic [IW-1:0]   tab_word;
  assign tab_addr = exec_reg.dst_m ? {2'h3, dmem[DA_TBLP]}
                                   : {dmem[DA_TBHP][1:0], dmem[DA_TBLP]};
  assign tab_word = pmem[tab_addr];

  // ==========================================================
  // ALU: arithmetic shares one adder with inverted operand for subtract
  logic [8:0] alu_r;
  logic [8:0] daa_t;
  logic [4:0] nib;
  logic [7:0] bx;
  logic       ci;
  logic       arith;
  logic       c_n;
  logic       ac_n;
  logic       z_keep;
  always_comb begin
    bx     = mem_rd;
    ci     = 1'b0;
    arith  = 1'b0;
    c_n    = flg_reg.c;
    z_keep = 1'b0;
    alu_r  = {1'b0, acc_reg};
    daa_t  = {1'b0, acc_reg} +
             (((acc_reg[3:0] > 4'h9) || flg_reg.ac) ? 9'h006 : 9'h000);
    case (exec_reg.op)
      OP_ADD: arith = 1'b1;
      OP_ADC: begin
        arith = 1'b1;
        ci    = flg_reg.c;
      end
      OP_SUB: begin
        arith = 1'b1;
        bx    = ~mem_rd;
        ci    = 1'b1;
      end
      OP_SBC: begin
        arith = 1'b1;
        bx    = ~mem_rd;
        ci    = flg_reg.c;
      end
      OP_DAA: begin
        c_n = (daa_t[7:4] > 4'h9) || flg_reg.c || daa_t[8];
        alu_r = daa_t + (c_n ? 9'h060 : 9'h000);
      end
      OP_AND: alu_r = {1'b0, acc_reg & mem_rd};
      OP_OR:  alu_r = {1'b0, acc_reg | mem_rd};
      OP_XOR: alu_r = {1'b0, acc_reg ^ mem_rd};
      OP_CPL: alu_r = {1'b0, ~mem_rd};
      OP_RR: begin
        alu_r  = {1'b0, mem_rd[0], mem_rd[7:1]};
        z_keep = 1'b1;
      end
      OP_RRC: begin
        alu_r  = {1'b0, flg_reg.c, mem_rd[7:1]};
        c_n    = mem_rd[0];
        z_keep = 1'b1;
      end
      OP_RL: begin
        alu_r  = {1'b0, mem_rd[6:0], mem_rd[7]};
        z_keep = 1'b1;
      end
      OP_RLC: begin
        alu_r  = {1'b0, mem_rd[6:0], flg_reg.c};
        c_n    = mem_rd[7];
        z_keep = 1'b1;
      end
      OP_INC: alu_r = {1'b0, mem_rd + 8'h01};
      OP_DEC: alu_r = {1'b0, mem_rd - 8'h01};
      default: alu_r = {1'b0, acc_reg};
    endcase
    nib  = {1'b0, acc_reg[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
    ac_n = arith ? nib[4] : flg_reg.ac;
    if (arith) begin
      alu_r = {1'b0, acc_reg} + {1'b0, bx} + {8'h00, ci};
      c_n   = alu_r[8];  // Carry set means no borrow on subtract
    end
  end

  // ==========================================================
  // Write-back and redirect decisions
  logic       wr_en;
  logic [7:0] wr_data;
  logic       pcl_wr;
  logic       skip_take;
  logic       redirect;
  logic       irq_ack;
  logic       push;
  logic       pop;
  logic [PC_W-1:0] pc_m1;
  logic [PC_W-1:0] stk_top;
  logic [PC_W-1:0] pc_tgt;
  assign wr_en     = exec_go && ((is_alu && exec_reg.dst_m) || is_mov || is_tab);
  assign wr_data   = is_tab ? tab_word[7:0] : is_mov ? acc_reg : alu_r[7:0];
  assign pcl_wr    = wr_en && (da == DA_PCL);
  assign skip_take = is_sz && (mem_rd == 8'h00);
  assign pc_m1     = pc_reg - 10'h001;
  assign stk_top   = (sp_reg == SP_FULL) ? stk_reg[1] : stk_reg[0];
  assign redirect  = exec_go &&
                     (is_jmp || is_call || is_ret || skip_take || pcl_wr || is_tab);
  // Table read replays the fetched word after a dummy cycle
  assign pc_tgt    = (is_jmp || is_call) ? jt :
                     is_ret ? stk_top :
                     pcl_wr ? {pc_reg[9:8], wr_data} :
                     is_tab ? pc_m1 :
                     pc_reg;
  // Entry waits for a valid fetched word so the return address is exact
  assign irq_ack   = run_reg && (ph_reg == PH_T4) && !redirect && pend_reg &&
                     emi_reg && (sp_reg != SP_FULL) && fetch_vld_reg;
  assign push      = (exec_go && is_call) || irq_ack;
  assign pop       = exec_go && is_ret;

  // ==========================================================
  // Program counter
  always_ff @(posedge core_clk) begin
    if (!rst_n) pc_reg <= RESET_VEC;
    else if (irq_ack) pc_reg <= IRQ_VEC;
    else if (redirect) pc_reg <= pc_tgt;
    else if (t1_go) pc_reg <= pc_reg + 10'h001;
  end

  // Fetch and execute stages overlap; a redirect voids the fetched word
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fetch_reg     <= '0;
      exec_reg      <= '0;
      fetch_vld_reg <= 1'b0;
      exec_vld_reg  <= 1'b0;
    end else if (t1_go) begin
      exec_reg      <= fetch_reg;
      exec_vld_reg  <= fetch_vld_reg;
      fetch_reg     <= psc_instr_t'(pmem[pc_reg]);
      fetch_vld_reg <= 1'b1;
    end else if (redirect || irq_ack) begin
      fetch_vld_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Return stack: pointer counts filled levels, zero is the top
  always_ff @(posedge core_clk) begin
    if (!rst_n) sp_reg <= 2'h0;
    else if (push && sp_reg != SP_FULL) sp_reg <= sp_reg + 2'h1;
    else if (pop && sp_reg != 2'h0) sp_reg <= sp_reg - 2'h1;
  end

  // Overflow shifts out the oldest entry rather than refusing the call
  always_ff @(posedge core_clk) begin
    if (push && sp_reg == SP_FULL) begin
      stk_reg[0] <= stk_reg[1];
      stk_reg[1] <= pc_m1;
    end else if (push) begin
      stk_reg[sp_reg[0]] <= pc_m1;
    end
  end

  // ==========================================================
  // Accumulator, flags, latch and data memory
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_reg  <= 8'h00;
      flg_reg  <= '0;
      table_high_latch_reg <= '0;
    end else begin
      if (exec_go && is_lit) acc_reg <= lit;
      else if (exec_go && is_alu && !exec_reg.dst_m) acc_reg <= alu_r[7:0];
      if (wr_en && da == DA_STATUS) flg_reg <= psc_flags_t'(wr_data[2:0]);
      else if (exec_go && is_alu)
        flg_reg <= '{ac: ac_n, c: c_n, z: z_keep ? flg_reg.z : (alu_r[7:0] == 8'h00)};
      if (exec_go && is_tab) table_high_latch_reg <= tab_word[IW-1:8];
    end
  end

  // The latch location ignores writes
  always_ff @(posedge core_clk) begin
    if (wr_en && da != DA_PCL && da != DA_TABLE_HIGH_LATCH && da != DA_STATUS) dmem[da] <= wr_data;
  end

  // ==========================================================
  // Bus slave: ready flags double as empty flags of the holding slots
  logic            awready_reg;
  logic            wready_reg;
  logic            bvalid_reg;
  logic [1:0]      bresp_reg;
  logic            arready_reg;
  logic            rvalid_reg;
  logic [1:0]      rresp_reg;
  logic [31:0]     rdata_reg;
  logic [7:0]      awa_q;
  logic [31:0]     wd_q;
  logic [3:0]      ws_q;
  logic            wr_fire;
  logic            wr_hit;
  logic            ctrl_wr;
  logic            paddr_wr;
  logic            pdata_wr;
  logic [7:0]      ara;
  logic            rd_hit;
  logic [31:0]     rd_mux;
  assign wr_fire  = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_hit   = awa_q[7:2] inside {REG_CTRL[7:2], REG_PADDR[7:2], REG_PDATA[7:2]};
  assign ctrl_wr  = wr_fire && awa_q[7:2] == REG_CTRL[7:2] && ws_q[0];
  assign paddr_wr = wr_fire && awa_q[7:2] == REG_PADDR[7:2] && ws_q[0];
  assign pdata_wr = wr_fire && awa_q[7:2] == REG_PDATA[7:2] && ws_q[0];
  assign ara      = s_axi_araddr;
  assign rd_hit   = ara[7:2] inside {REG_CTRL[7:2], REG_STAT[7:2], REG_PADDR[7:2],
                                     REG_PDATA[7:2], REG_CORE[7:2]};
  assign rd_mux   =
    (ara[7:2] == REG_CTRL[7:2])  ? {29'h0, emi_reg, pend_reg, run_reg} :
    (ara[7:2] == REG_STAT[7:2])  ? {13'h0, emi_reg, pend_reg, flg_reg, ph_reg,
                                    sp_reg, pc_reg} :
    (ara[7:2] == REG_PADDR[7:2]) ? {22'h0, paddr_reg} :
    (ara[7:2] == REG_PDATA[7:2]) ? {18'h0, pmem[paddr_reg]} :
    (ara[7:2] == REG_CORE[7:2])  ? {18'h0, table_high_latch_reg, acc_reg} : 32'h0000_0000;

  // Write channel: address and data land in either order
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awa_q       <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end else if (wr_fire) awready_reg <= 1'b1;
      if (s_axi_wvalid && wready_reg) begin
        wd_q       <= s_axi_wdata;
        ws_q       <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end else if (wr_fire) wready_reg <= 1'b1;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) bvalid_reg <= 1'b0;
    end
  end

  // Read channel: one outstanding read, answered the cycle after acceptance
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // ==========================================================
  // Control bits; a request set by software beats a same-cycle acknowledge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_reg  <= 1'b0;
      emi_reg  <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      if (ctrl_wr) run_reg <= wd_q[CTRL_RUN];
      if (ctrl_wr && wd_q[CTRL_IRQ]) pend_reg <= 1'b1;
      else if (irq_ack) pend_reg <= 1'b0;
      if (ctrl_wr) emi_reg <= wd_q[CTRL_EMI];
      else if (irq_ack) emi_reg <= 1'b0;
      else if (pop && exec_reg.addr[0]) emi_reg <= 1'b1;
    end
  end

  // Loader: data port writes auto-increment the load address
  always_ff @(posedge core_clk) begin
    if (!rst_n) paddr_reg <= 10'h000;
    else if (paddr_wr) paddr_reg <= wd_q[PC_W-1:0];
    else if (pdata_wr) paddr_reg <= paddr_reg + 10'h001;
  end
  always_ff @(posedge core_clk) begin
    if (pdata_wr) pmem[paddr_reg] <= wd_q[IW-1:0];
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_phase_wrap: assert property (
    ph_reg == PH_T4 && run_reg |=> ph_reg == PH_T1)
    else $error("phase did not wrap to T1");
  a_fetch_step: assert property (
    t1_go |=> pc_reg == $past(pc_reg) + 10'h001)
    else $error("counter did not step on fetch");
  a_pipe_overlap: assert property (
    t1_go && fetch_vld_reg |=> exec_vld_reg)
    else $error("fetched word not passed to execute");
  a_branch_dummy: assert property (
    exec_go && (is_jmp || is_call) ##1 run_reg |=> !exec_vld_reg)
    else $error("branch did not insert a dummy cycle");
  a_skip_dummy: assert property (
    exec_go && skip_take ##1 run_reg |=> !exec_vld_reg)
    else $error("taken skip executed the next word");
  a_jump_load: assert property (
    exec_go && is_jmp |=> pc_reg == $past(jt))
    else $error("jump target not loaded");
  a_pcl_page: assert property (
    pcl_wr |=> pc_reg == {$past(pc_reg[9:8]), $past(wr_data)})
    else $error("low byte write left the page");
  a_ret_pop: assert property (
    pop && sp_reg != 2'h0 |=> pc_reg == $past(stk_top) && sp_reg == $past(sp_reg) - 2'h1)
    else $error("return did not restore counter");
  a_stack_drop: assert property (
    exec_go && is_call && sp_reg == SP_FULL |=>
      stk_reg[0] == $past(stk_reg[1]) && sp_reg == SP_FULL)
    else $error("overflow did not drop oldest entry");
  // Without a redirect the counter may only hold or step, so a vector load shows up
  a_irq_held: assert property (
    pend_reg && sp_reg == SP_FULL && !redirect |=>
      pend_reg && (pc_reg == $past(pc_reg) || pc_reg == $past(pc_reg) + 10'h001))
    else $error("interrupt taken or lost with full stack");
  a_table_high_latch_ro: assert property (
    !(exec_go && is_tab) |=> $stable(table_high_latch_reg))
    else $error("latch changed without table read");
  a_reset_vec: assert property (
    disable iff (1'b0) $rose(rst_n) |-> pc_reg == RESET_VEC && sp_reg == 2'h0)
    else $error("reset did not clear counter and pointer");

  c_jump:     cover property (exec_go && is_jmp ##4 exec_vld_reg);
  c_irq:      cover property (irq_ack);
  c_overflow: cover property (exec_go && is_call && sp_reg == SP_FULL);
  c_table:    cover property (exec_go && is_tab);

endmodule  // psc_core
`default_nettype wire

/* File: tb/psc_prog_model.sv */
// Program image that the core runs from its program memory
`timescale 1ns/1ps
`default_nettype none
module psc_prog_model (
  input  wire logic [2:0]  idx,
  output logic      [13:0] word
);
  // ==========================================================
  // Literal, call, self loop; subroutine at 0x010 loads and returns
  always_comb begin
    case (idx)
      3'h0:    word = 14'h3805; // acc = 0x05
      3'h1:    word = 14'h1010; // call 0x010
      3'h2:    word = 14'h0802; // jump to self
      3'h3:    word = 14'h383C; // acc = 0x3C
      default: word = 14'h1800; // return
    endcase
  end
endmodule // psc_prog_model
`default_nettype wire

/* File: tb/test_program_sequencer_core.sv */
// Bench for the program sequencer core over its register bus
`timescale 1ns/1ps
`default_nettype none
module test_program_sequencer_core;
  import psc_pkg::*;
  logic core_clk, rst_n, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic awready, wready, arready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  ph;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  idx;
  logic [13:0] word;
  int n_fail, n_checks;
  psc_core dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .instruction_phase_clocks(ph));
  psc_prog_model pm (.idx(idx), .word(word));
  // ==========================================================
  // Bus tasks: ready is sampled settled, release follows the taking edge
  // An idle edge ends each task so back-to-back calls never drive a strobe twice
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit ta, tw, hb;
    ta = 0; tw = 0;
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      #1 hb = awvalid && awready; ta |= hb; tw |= wvalid && wready; hb = wvalid && wready;
      @(posedge core_clk);
      if (ta) awvalid <= 0;
      if (hb) wvalid <= 0;
    end while (!(ta && tw));
    do begin #1 hb = bvalid; rs = bresp; @(posedge core_clk); end while (!hb);
    bready <= 0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    bit h;
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin #1 h = arready; @(posedge core_clk); end while (!h);
    arvalid <= 0;
    do begin #1 h = rvalid; v = rdata; rs = rresp; @(posedge core_clk); end while (!h);
    rready <= 0;
    @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin n_fail++; $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp); end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk({28'h0, ph}, 32'h0, "phases idle");
    rd(REG_STAT, d, r);
    chk({20'h0, d[11:0]}, 32'h0, "pc and stack pointer");
    $display("reset test done");
  endtask
  task automatic t_unmapped();
    rd(8'h40, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(8'h40, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    $display("unmapped test done");
  endtask
  task automatic t_run();
    wr(REG_PADDR, 32'h0, r);
    for (int i = 0; i < 5; i++) begin
      if (i == 3) wr(REG_PADDR, 32'h10, r);
      idx = 3'(i);
      @(posedge core_clk);
      wr(REG_PDATA, {18'h0, word}, r);
    end
    wr(REG_CTRL, 32'h1, r);
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      #1 d = {28'h0, ph};
      @(posedge core_clk); #1
      chk({28'h0, ph}, {28'h0, d[2:0], d[3]}, "phase rotates");
    end
    repeat (200) @(posedge core_clk);
    rd(REG_CORE, d, r);
    chk({24'h0, d[7:0]}, 32'h3C, "subroutine ran");
    rd(REG_STAT, d, r);
    chk({30'h0, d[11:10]}, 32'h0, "stack popped");
    chk({31'h0, d[9:0] >= 10'h002 && d[9:0] <= 10'h004}, 32'h1, "loop page");
    $display("run test done");
  endtask
  // Mid-run reset, then three nested calls overflow the stack and a later interrupt waits on it;
  // after the wait the return chain must land on the entry that replaced the lost one
  task automatic t_stack();
    logic [13:0] img [22];
    img = '{14'h1008, 14'h0801, 14'h0000, 14'h0000, 14'h3877, 14'h1801, 14'h0000,
            14'h0000, 14'h100C, 14'h1800, 14'h0000, 14'h0000, 14'h1010, 14'h1800,
            14'h0000, 14'h0000, 14'h3840, 14'h3020, 14'h0760, 14'h2020, 14'h0812,
            14'h1800};
    rst_n <= 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    rd(REG_STAT, d, r);
    chk({16'h0, ph, d[11:0]}, 32'h0, "reset mid-run");
    wr(REG_PADDR, 32'h0, r);
    for (int i = 0; i < 22; i++) wr(REG_PDATA, {18'h0, img[i]}, r);
    wr(REG_CTRL, 32'h1, r);
    repeat (100) @(posedge core_clk);
    wr(REG_CTRL, 32'h7, r);
    rd(REG_STAT, d, r);
    chk({30'h0, d[17], d[11]}, 32'h3, "irq held on full stack");
    repeat (1500) @(posedge core_clk);
    rd(REG_STAT, d, r);
    chk({28'h0, d[18:17], d[11:10]}, 32'h8, "irq served after return");
    chk({31'h0, d[9:0] >= 10'h009 && d[9:0] <= 10'h00B}, 32'h1, "oldest entry lost");
    rd(REG_CORE, d, r);
    chk({24'h0, d[7:0]}, 32'h77, "service routine ran");
    $display("stack test done");
  endtask
  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial begin core_clk = 0; forever #5 core_clk = ~core_clk; end
  initial begin
    rst_n = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; idx = 0; n_fail = 0; n_checks = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    t_reset();
    t_unmapped();
    t_run();
    t_stack();
    stop_test();
  end
  initial begin #50000; n_fail++; stop_test(); end
endmodule // test_program_sequencer_core
`default_nettype wire
